// ---- core/aers_log_fifo.sv ----
// small violation log memory: push on a violation, pop on a csr read.
// assumes push is never issued while full; flush empties it at once but keeps a push of the same cycle.
`timescale 1ns/1ps
module aers_log_fifo
   import aers_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] din,
   input  wire logic             pop,
   input  wire logic             flush,
   output logic      [WIDTH-1:0] dout,
   output logic                  full,
   output logic                  empty
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d, wr_at;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [WIDTH-1:0] dout_q;

   // pointer step that wraps at any depth, not only powers of two
   function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p);
      step = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : step

   // ****************************************************************
   // pointers and fill count
   // ****************************************************************
   assign wr_at    = flush ? '0 : wr_ptr_q;
   assign wr_ptr_d = push ? step(wr_at) : wr_at;
   assign rd_ptr_d = flush ? '0 : (pop && !empty) ? step(rd_ptr_q) : rd_ptr_q;
   assign cnt_d    = flush ? CNT_W'(push) :
                     CNT_W'(cnt_q + CNT_W'(push) - CNT_W'(pop && !empty));
   assign full     = (cnt_q == CNT_W'(DEPTH));
   assign empty    = (cnt_q == '0);
   assign dout     = dout_q;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q    <= '0;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         cnt_q    <= cnt_d;
      end
   end

   // storage has no reset; head word is registered with write bypass
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_q[wr_at] <= din;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dout_q <= '0;
      end else begin
         dout_q <= (push && wr_at == rd_ptr_d) ? din : mem_q[rd_ptr_d];
      end
   end

endmodule : aers_log_fifo

// ---- core/aers_pkg.sv ----
// shared constants of the error response slave: csr map, fields, codes.
// assumes a byte-addressed csr port with one 32-bit word per register.
package aers_pkg;

   // ****************************************************************
   // csr byte offsets
   // ****************************************************************
   localparam logic [8:0] AERS_OFF_STATUS    = 9'h000;
   localparam logic [8:0] AERS_OFF_RD_STAT   = 9'h100;
   localparam logic [8:0] AERS_OFF_RD_BTYPE  = 9'h104;
   localparam logic [8:0] AERS_OFF_RD_BLEN   = 9'h108;
   localparam logic [8:0] AERS_OFF_RD_BSIZE  = 9'h10c;
   localparam logic [8:0] AERS_OFF_WR_STAT   = 9'h190;
   localparam logic [8:0] AERS_OFF_WR_ID     = 9'h194;
   localparam logic [8:0] AERS_OFF_WR_ADDR_L = 9'h198;
   localparam logic [8:0] AERS_OFF_WR_ADDR_H = 9'h19c;
   localparam logic [8:0] AERS_OFF_WR_DATA0  = 9'h1a0;
   localparam logic [8:0] AERS_OFF_WR_DATA1  = 9'h1a4;
   localparam logic [8:0] AERS_OFF_WR_DATA2  = 9'h1a8;
   localparam logic [8:0] AERS_OFF_WR_DATA3  = 9'h1ac;

   // ****************************************************************
   // status register bits and reset value
   // ****************************************************************
   localparam int AERS_ST_WR_INT = 0;
   localparam int AERS_ST_RD_INT = 1;
   localparam int AERS_ST_WR_OVF = 2;
   localparam int AERS_ST_RD_OVF = 3;
   localparam logic [31:0] AERS_RESET_VALUE = 32'h0000_0000;

   // ****************************************************************
   // log status word fields
   // ****************************************************************
   localparam int AERS_LOG_VALID   = 0;
   localparam int AERS_LOG_PROT_LO = 1;
   localparam int AERS_LOG_SIZE_LO = 4;
   localparam int AERS_LOG_LEN_LO  = 7;
   localparam int AERS_LOG_TYPE_LO = 11;

   // ****************************************************************
   // axi widths and response code
   // ****************************************************************
   localparam int AERS_LEN_W   = 4;
   localparam int AERS_SIZE_W  = 3;
   localparam int AERS_BURST_W = 2;
   localparam int AERS_PROT_W  = 3;
   localparam logic [1:0] AERS_RESP_DECERR = 2'h3;

   // ****************************************************************
   // documented parameter limits
   // ****************************************************************
   localparam int AERS_ID_W_MAX    = 8;
   localparam int AERS_ADDR_W_MIN  = 8;
   localparam int AERS_ADDR_W_MAX  = 64;
   localparam int AERS_DATA_W_MAX  = 128;
   localparam int AERS_DEPTH_MAX   = 16;

endpackage : aers_pkg

// ---- core/aers_slave.sv ----
// default target for undecoded axi space: every cycle ends in decerr,
// with an optional csr port that logs offenders in two small fifos.
// assumes an axi3 master on one side and polling or irq software.
`timescale 1ns/1ps
module aers_slave
   import aers_pkg::*;
#(
   parameter int ID_W      = 4,
   parameter int ADDR_W    = 32,
   parameter int DATA_W    = 32,
   parameter bit CSR_EN    = 1'b1,
   parameter int LOG_DEPTH = 4
) (
   input  wire logic                    sys_clk,
   input  wire logic                    sys_rst,
   // axi write address
   input  wire logic [ID_W-1:0]         awid,
   input  wire logic [ADDR_W-1:0]       awaddr,
   input  wire logic [AERS_LEN_W-1:0]   awlen,
   input  wire logic [AERS_SIZE_W-1:0]  awsize,
   input  wire logic [AERS_BURST_W-1:0] awburst,
   input  wire logic [AERS_PROT_W-1:0]  awprot,
   input  wire logic                    awvalid,
   output logic                         awready,
   // axi write data
   input  wire logic [ID_W-1:0]         wid,
   input  wire logic [DATA_W-1:0]       wdata,
   input  wire logic [DATA_W/8-1:0]     wstrb,
   input  wire logic                    wlast,
   input  wire logic                    wvalid,
   output logic                         wready,
   // axi write response
   output logic      [ID_W-1:0]         bid,
   output logic      [1:0]              bresp,
   output logic                         bvalid,
   input  wire logic                    bready,
   // axi read address
   input  wire logic [ID_W-1:0]         arid,
   input  wire logic [ADDR_W-1:0]       araddr,
   input  wire logic [AERS_LEN_W-1:0]   arlen,
   input  wire logic [AERS_SIZE_W-1:0]  arsize,
   input  wire logic [AERS_BURST_W-1:0] arburst,
   input  wire logic [AERS_PROT_W-1:0]  arprot,
   input  wire logic                    arvalid,
   output logic                         arready,
   // axi read data
   output logic      [ID_W-1:0]         rid,
   output logic      [DATA_W-1:0]       rdata,
   output logic      [1:0]              rresp,
   output logic                         rlast,
   output logic                         rvalid,
   input  wire logic                    rready,
   // csr port, byte addressed
   input  wire logic [8:0]              csr_address,
   input  wire logic                    csr_read,
   input  wire logic                    csr_write,
   input  wire logic [31:0]             csr_writedata,
   output logic      [31:0]             csr_readdata,
   output logic                         csr_readdatavalid,
   output logic                         irq
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   generate
      if (ID_W < 1 || ID_W > AERS_ID_W_MAX) begin : g_bad_id
         $error("aers_slave: ID_W out of range");
      end
      if (ADDR_W < AERS_ADDR_W_MIN || ADDR_W > AERS_ADDR_W_MAX) begin : g_bad_addr
         $error("aers_slave: ADDR_W out of range");
      end
      if (DATA_W != 32 && DATA_W != 64 && DATA_W != AERS_DATA_W_MAX) begin : g_bad_data
         $error("aers_slave: DATA_W must be 32, 64 or 128");
      end
      if (LOG_DEPTH < 1 || LOG_DEPTH > AERS_DEPTH_MAX) begin : g_bad_depth
         $error("aers_slave: LOG_DEPTH out of range");
      end
   endgenerate

   localparam int RD_ENT_W = AERS_BURST_W + AERS_LEN_W + AERS_SIZE_W;
   localparam int WR_INFO_W = RD_ENT_W + AERS_PROT_W;
   localparam int WR_ENT_W = ID_W + ADDR_W + DATA_W + WR_INFO_W;

   // zero-extend up to 128 bits so 32-bit slices can be cut uniformly
   function automatic logic [127:0] widen(input logic [127:0] v, input int w);
      logic [127:0] m;
      m     = (w >= 128) ? '1 : ((128'h1 << w) - 128'h1);
      widen = v & m;
   endfunction : widen

   function automatic logic [31:0] slice(input logic [127:0] v, input int k);
      slice = v[k*32 +: 32];
   endfunction : slice

   typedef enum logic [2:0] {
      AERS_WR_IDLE = 3'b001,
      AERS_WR_DATA = 3'b010,
      AERS_WR_RESP = 3'b100
   } aers_wr_state_t;

   typedef enum logic [1:0] {
      AERS_RD_IDLE = 2'b01,
      AERS_RD_DATA = 2'b10
   } aers_rd_state_t;

   aers_wr_state_t          wr_state_q, wr_state_d;
   aers_rd_state_t          rd_state_q, rd_state_d;
   logic [ID_W-1:0]         bid_q, rid_q;
   logic [AERS_LEN_W-1:0]   rcnt_q, rcnt_d;
   logic [WR_INFO_W-1:0]    aw_info_q;
   logic [ID_W-1:0]         aw_id_q;
   logic [ADDR_W-1:0]       aw_addr_q;
   logic [DATA_W-1:0]       first_q;
   logic                    first_seen_q;
   logic                    aw_hs, w_hs, b_hs, ar_hs, r_hs, w_end;

   // ****************************************************************
   // write channel: one burst at a time, decerr response
   // ****************************************************************
   assign aw_hs  = awvalid && awready;
   assign w_hs   = wvalid && wready;
   assign b_hs   = bvalid && bready;
   assign w_end  = w_hs && wlast;
   assign awready = (wr_state_q == AERS_WR_IDLE);
   assign wready  = (wr_state_q == AERS_WR_DATA);
   assign bvalid  = (wr_state_q == AERS_WR_RESP);
   assign bresp   = AERS_RESP_DECERR;
   assign bid     = bid_q;

   always_comb begin
      wr_state_d = wr_state_q;
      unique case (wr_state_q)
         AERS_WR_IDLE: if (aw_hs) wr_state_d = AERS_WR_DATA;
         AERS_WR_DATA: if (w_end) wr_state_d = AERS_WR_RESP;
         AERS_WR_RESP: if (b_hs)  wr_state_d = AERS_WR_IDLE;
      endcase
   end

   // address fields held until the last beat, first data beat caught
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_state_q   <= AERS_WR_IDLE;
         bid_q        <= '0;
         aw_id_q      <= '0;
         aw_addr_q    <= '0;
         aw_info_q    <= '0;
         first_q      <= '0;
         first_seen_q <= 1'b0;
      end else begin
         wr_state_q <= wr_state_d;
         if (aw_hs) begin
            bid_q        <= awid;
            aw_id_q      <= awid;
            aw_addr_q    <= awaddr;
            aw_info_q    <= {awburst, awlen, awsize, awprot};
            first_seen_q <= 1'b0;
         end else if (w_hs && !first_seen_q) begin
            first_q      <= wdata;
            first_seen_q <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // read channel: independent of the write side, len+1 error beats
   // ****************************************************************
   assign ar_hs   = arvalid && arready;
   assign r_hs    = rvalid && rready;
   assign arready = (rd_state_q == AERS_RD_IDLE);
   assign rvalid  = (rd_state_q == AERS_RD_DATA);
   assign rlast   = rvalid && (rcnt_q == '0);
   assign rresp   = AERS_RESP_DECERR;
   assign rdata   = '0;
   assign rid     = rid_q;
   assign rcnt_d  = ar_hs ? arlen : (r_hs ? rcnt_q - 1'b1 : rcnt_q);

   always_comb begin
      rd_state_d = rd_state_q;
      unique case (rd_state_q)
         AERS_RD_IDLE: if (ar_hs)          rd_state_d = AERS_RD_DATA;
         AERS_RD_DATA: if (r_hs && rlast)  rd_state_d = AERS_RD_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_state_q <= AERS_RD_IDLE;
         rid_q      <= '0;
         rcnt_q     <= '0;
      end else begin
         rd_state_q <= rd_state_d;
         rcnt_q     <= rcnt_d;
         if (ar_hs) begin
            rid_q <= arid;
         end
      end
   end

   // ****************************************************************
   // violation logging and status flags
   // ****************************************************************
   logic                rd_viol, wr_viol, rd_push, wr_push, rd_pop, wr_pop;
   logic                rd_full, rd_empty, wr_full, wr_empty;
   logic                rd_flush, wr_flush, csr_wr_st, csr_rd;
   logic [RD_ENT_W-1:0] rd_head;
   logic [WR_ENT_W-1:0] wr_head, wr_entry;
   logic                rd_int_q, wr_int_q, rd_ovf_q, wr_ovf_q;
   logic                rd_int_d, wr_int_d, rd_ovf_d, wr_ovf_d;
   logic                rd_valid, wr_valid;
   logic [8:0]          wr_pop_off;

   // a write is logged at its last beat so the first data is known
   assign rd_viol  = CSR_EN && ar_hs;
   assign wr_viol  = CSR_EN && w_end;
   assign rd_push  = rd_viol && !rd_full;
   assign wr_push  = wr_viol && !wr_full;
   assign wr_entry = {aw_id_q, aw_addr_q, first_seen_q ? first_q : wdata, aw_info_q};

   assign csr_wr_st = CSR_EN && csr_write && (csr_address[8:2] == AERS_OFF_STATUS[8:2]);
   assign csr_rd    = CSR_EN && csr_read;
   assign rd_flush  = csr_wr_st && csr_writedata[AERS_ST_RD_INT];
   assign wr_flush  = csr_wr_st && csr_writedata[AERS_ST_WR_INT];

   // a log entry is only meaningful while its flag is up
   assign rd_valid   = rd_int_q && !rd_empty;
   assign wr_valid   = wr_int_q && !wr_empty;
   assign wr_pop_off = (DATA_W == 32) ? AERS_OFF_WR_DATA0 : AERS_OFF_WR_DATA3;
   assign rd_pop     = csr_rd && rd_valid &&
                       (csr_address[8:2] == AERS_OFF_RD_BSIZE[8:2]);
   assign wr_pop     = csr_rd && wr_valid &&
                       (csr_address[8:2] == wr_pop_off[8:2]);

   // set wins over a write-one clear; drained flag drops by itself
   assign rd_int_d = rd_viol || (rd_int_q && !rd_flush && !rd_empty);
   assign wr_int_d = wr_viol || (wr_int_q && !wr_flush && !wr_empty);
   assign rd_ovf_d = (rd_viol && rd_full) ||
                     (rd_ovf_q && !(csr_wr_st && csr_writedata[AERS_ST_RD_OVF]));
   assign wr_ovf_d = (wr_viol && wr_full) ||
                     (wr_ovf_q && !(csr_wr_st && csr_writedata[AERS_ST_WR_OVF]));

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_int_q <= AERS_RESET_VALUE[AERS_ST_RD_INT];
         wr_int_q <= AERS_RESET_VALUE[AERS_ST_WR_INT];
         rd_ovf_q <= AERS_RESET_VALUE[AERS_ST_RD_OVF];
         wr_ovf_q <= AERS_RESET_VALUE[AERS_ST_WR_OVF];
      end else begin
         rd_int_q <= rd_int_d;
         wr_int_q <= wr_int_d;
         rd_ovf_q <= rd_ovf_d;
         wr_ovf_q <= wr_ovf_d;
      end
   end

   assign irq = rd_int_q || wr_int_q || rd_ovf_q || wr_ovf_q;

   aers_log_fifo #(
      .WIDTH (RD_ENT_W),
      .DEPTH (LOG_DEPTH)
   ) u_rd_log (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .push    (rd_push),
      .din     ({arburst, arlen, arsize}),
      .pop     (rd_pop),
      .flush   (rd_flush),
      .dout    (rd_head),
      .full    (rd_full),
      .empty   (rd_empty)
   );

   aers_log_fifo #(
      .WIDTH (WR_ENT_W),
      .DEPTH (LOG_DEPTH)
   ) u_wr_log (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .push    (wr_push),
      .din     (wr_entry),
      .pop     (wr_pop),
      .flush   (wr_flush),
      .dout    (wr_head),
      .full    (wr_full),
      .empty   (wr_empty)
   );

   // ****************************************************************
   // csr read-back
   // ****************************************************************
   logic [AERS_BURST_W-1:0] rh_type;
   logic [AERS_LEN_W-1:0]   rh_len;
   logic [AERS_SIZE_W-1:0]  rh_size;
   logic [WR_INFO_W-1:0]    wh_info;
   logic [127:0]            wh_id, wh_addr, wh_data;
   logic [31:0]             st_word, rd_stat_word, wr_stat_word, rdata_mux;
   logic [31:0]             csr_readdata_q;
   logic                    csr_rvalid_q;
   logic [6:0]              word;

   assign {rh_type, rh_len, rh_size} = rd_head;
   assign wh_info = wr_head[WR_INFO_W-1:0];
   assign wh_data = widen(128'(wr_head[WR_INFO_W +: DATA_W]), DATA_W);
   assign wh_addr = widen(128'(wr_head[WR_INFO_W+DATA_W +: ADDR_W]), ADDR_W);
   assign wh_id   = widen(128'(wr_head[WR_INFO_W+DATA_W+ADDR_W +: ID_W]), ID_W);

   assign st_word      = {28'h0, rd_ovf_q, wr_ovf_q, rd_int_q, wr_int_q};
   assign rd_stat_word = {31'h0, rd_valid};
   // burst type, length, size and prot sit in the fifo in this order;
   // a drained log would show a stale slot, so its fields read zero
   assign wr_stat_word = {19'h0, wr_valid ? wh_info : WR_INFO_W'(0), wr_valid};
   assign word         = csr_address[8:2];

   assign rdata_mux =
      (word == AERS_OFF_STATUS[8:2])    ? st_word :
      (word == AERS_OFF_RD_STAT[8:2])   ? rd_stat_word :
      (word == AERS_OFF_RD_BTYPE[8:2])  ? 32'(rh_type) :
      (word == AERS_OFF_RD_BLEN[8:2])   ? 32'(rh_len) :
      (word == AERS_OFF_RD_BSIZE[8:2])  ? 32'(rh_size) :
      (word == AERS_OFF_WR_STAT[8:2])   ? wr_stat_word :
      (word == AERS_OFF_WR_ID[8:2])     ? slice(wh_id, 0) :
      (word == AERS_OFF_WR_ADDR_L[8:2]) ? slice(wh_addr, 0) :
      (word == AERS_OFF_WR_ADDR_H[8:2]) ? slice(wh_addr, 1) :
      (word == AERS_OFF_WR_DATA0[8:2])  ? slice(wh_data, 0) :
      (word == AERS_OFF_WR_DATA1[8:2])  ? slice(wh_data, 1) :
      (word == AERS_OFF_WR_DATA2[8:2])  ? slice(wh_data, 2) :
      (word == AERS_OFF_WR_DATA3[8:2])  ? slice(wh_data, 3) : 32'h0000_0000;

   // one-cycle read latency; without csr support everything reads zero
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         csr_readdata_q <= 32'h0000_0000;
         csr_rvalid_q   <= 1'b0;
      end else begin
         csr_rvalid_q <= csr_read;
         if (csr_read) begin
            csr_readdata_q <= CSR_EN ? rdata_mux : 32'h0000_0000;
         end
      end
   end

   assign csr_readdata      = csr_readdata_q;
   assign csr_readdatavalid = csr_rvalid_q;

endmodule : aers_slave

// ---- dv/aers_axi_master.sv ----
// axi master model: one burst a direction at a time, prompt or slow ready.
// assumes aers_slave opposite and tasks entered at a falling edge.
`timescale 1ns/1ps
module aers_axi_master (
   input  wire logic        sys_clk, awready, wready, bvalid, arready, rvalid, rlast,
   output logic      [3:0]  awid, awlen, arlen,
   output logic      [31:0] awaddr, wdata, araddr,
   output logic      [2:0]  awsize, awprot, arsize,
   output logic      [1:0]  awburst, arburst,
   output logic             awvalid, wvalid, wlast, bready, arvalid, rready
);
   logic [31:0] nbeats;   // beats seen in the last read burst
   initial {awid, awlen, arlen, awaddr, wdata, araddr, awsize, awprot, arsize} = '0;
   initial {awburst, arburst, awvalid, wvalid, wlast, bready, arvalid, rready} = '0;
   // ****************************************************************
   // write burst: beats of one burst only, response taken before next
   // ****************************************************************
   task automatic wr(input logic [3:0] i, l, input logic [31:0] a, d,
                     input logic [2:0] s, p, input logic [1:0] b, input int st);
      {awid, awaddr, awlen, awsize, awburst, awprot, awvalid} = {i, a, l, s, b, p, 1'b1};
      do @(posedge sys_clk); while (!awready);
      @(negedge sys_clk);
      {awvalid, awaddr} = {1'b0, ~a};   // released lines stop showing old value
      for (int k = 0; k <= l; k++) begin
         {wdata, wlast, wvalid} = {d + k, k == l, 1'b1};
         do @(posedge sys_clk); while (!wready);
         @(negedge sys_clk);
      end
      {wvalid, wlast, wdata} = {2'b0, ~wdata};
      repeat (st) @(negedge sys_clk);   // slow master lets the response wait
      bready = 1;
      do @(posedge sys_clk); while (!bvalid);
      @(negedge sys_clk);
      bready = 0;
   endtask : wr
   // read burst: beats counted up to the last one
   task automatic rd(input logic [31:0] a, input logic [3:0] l, input logic [2:0] s,
                     input logic [1:0] b, input int st);
      {araddr, arlen, arsize, arburst, arvalid} = {a, l, s, b, 1'b1};
      do @(posedge sys_clk); while (!arready);
      @(negedge sys_clk);
      {arvalid, araddr} = {1'b0, ~a};
      repeat (st) @(negedge sys_clk);
      {rready, nbeats} = {1'b1, 32'h0};
      do begin
         @(posedge sys_clk);
         nbeats += rvalid;
      end while (!(rvalid && rlast));
      @(negedge sys_clk);
      rready = 0;
   endtask : rd
endmodule : aers_axi_master

// ---- dv/aers_monitor.sv ----
// checker of the error response slave: handshakes, decerr codes, csr answer.
// assumes it is bound into aers_slave and sees only that module's ports.
`timescale 1ns/1ps
module aers_monitor
   import aers_pkg::*;
(
   input wire logic       sys_clk, sys_rst, awvalid, awready, wvalid, wready, wlast,
   input wire logic       bvalid, bready, arvalid, arready, rvalid, rready, rlast,
   input wire logic       csr_read, csr_readdatavalid, irq,
   input wire logic [1:0] bresp, rresp
);
   // ****************************************************************
   // properties, all in the one clock domain
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_b_decerr: assert property (bvalid |-> bresp == AERS_RESP_DECERR)
      else $error("write response not decerr");
   a_r_decerr: assert property (rvalid |-> rresp == AERS_RESP_DECERR)
      else $error("read response not decerr");
   a_w_after_aw: assert property (awvalid && awready |=> wready)
      else $error("no wready after write address");
   a_b_after_last: assert property (wvalid && wready && wlast |=> bvalid)
      else $error("no write response after last beat");
   a_b_holds: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped unanswered");
   a_aw_one_out: assert property (wready || bvalid |-> !awready)
      else $error("second write accepted");
   a_r_after_ar: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read not answered or second read accepted");
   a_r_last_done: assert property (rvalid && rready && rlast |=> arready && !rvalid)
      else $error("read channel not idle after last beat");
   a_csr_answer: assert property (csr_readdatavalid == $past(csr_read))
      else $error("csr read answer not one cycle later");
   a_irq_cause: assert property ($rose(irq) |-> $past(wvalid && wready && wlast
                                  || arvalid && arready))
      else $error("irq rose without a violation");
endmodule : aers_monitor

// ---- dv/aers_tb.sv ----
// self-checking bench of aers_slave with an axi master model and csr tasks.
// assumes default parameters: 4-bit id, 32-bit address and data, depth 4.
`timescale 1ns/1ps
module tb
   import aers_pkg::*;
;
   logic        sys_clk = 0, sys_rst = 1, csr_read = 0, csr_write = 0;
   logic        awvalid, awready, wvalid, wready, wlast, bvalid, bready, irq;
   logic        arvalid, arready, rvalid, rready, rlast, csr_readdatavalid;
   logic [3:0]  awid, bid, rid, awlen, arlen;
   logic [31:0] awaddr, araddr, wdata, rdata, csr_readdata, v, csr_writedata = 0;
   logic [31:0] ws[5], wi[5], wa[5], wd[5];
   logic [2:0]  awsize, arsize, awprot;
   logic [1:0]  awburst, arburst, bresp, rresp;
   logic [8:0]  csr_address = 0;
   int          num_errors = 0, cmp_count = 0, seed = 72427, cyc = 0;
   aers_slave dut (.*, .wid(4'h0), .wstrb(4'hf), .arid(4'h5), .arprot(3'h2));
   aers_axi_master mst (.*);
   always #12.5 sys_clk = ~sys_clk;
   // hang guard: far above the length of the sequence
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         summarize();
      end
   end
   // ****************************************************************
   // compare, csr access and closing tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] g, e);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic rc(input logic [8:0] a, input logic [31:0] e);
      @(negedge sys_clk);
      {csr_address, csr_read} = {a, 1'b1};
      @(negedge sys_clk);
      csr_read = 0;
      chk(csr_readdata, e);
   endtask : rc
   task automatic cw(input logic [8:0] a, input logic [31:0] d);
      @(negedge sys_clk);
      {csr_address, csr_writedata, csr_write} = {a, d, 1'b1};
      @(negedge sys_clk);
      csr_write = 0;
   endtask : cw
   task automatic summarize();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   // expected write log status word
   function automatic logic [31:0] wsw(input logic [31:0] r);
      return {19'h0, r[12:11], r[7:4], r[10:8], r[15:13], 1'b1};
   endfunction : wsw
   initial begin
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk) sys_rst = 0;
      rc(AERS_OFF_STATUS, AERS_RESET_VALUE);
      // five random writes into a four-deep log, last one overflows
      for (int i = 0; i < 5; i++) begin
         {v, wa[i], wd[i]} = {$random(seed), $random(seed), $random(seed)};
         {ws[i], wi[i]} = {wsw(v), 28'h0, v[3:0]};
         mst.wr(v[3:0], v[7:4], wa[i], wd[i], v[10:8], v[15:13], v[12:11], i);
      end
      rc(AERS_OFF_STATUS, 32'h5);
      chk({31'h0, irq}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         rc(AERS_OFF_WR_STAT, ws[i]);
         rc(AERS_OFF_WR_ID, wi[i]);
         rc(AERS_OFF_WR_ADDR_L, wa[i]);
         rc(AERS_OFF_WR_ADDR_H, 32'h0);
         rc(AERS_OFF_WR_DATA0, wd[i]);
      end
      rc(AERS_OFF_WR_STAT, 32'h0);
      rc(AERS_OFF_STATUS, 32'h4);
      cw(AERS_OFF_STATUS, 32'h4);
      rc(AERS_OFF_STATUS, 32'h0);
      // read and write at once, read master slow
      v = $random(seed);
      fork
         mst.rd(v, v[3:0], v[6:4], v[8:7], 3);
         mst.wr(4'h9, 4'h0, 32'h0, 32'h0, 3'h2, 3'h0, 2'h1, 0);
      join
      chk(mst.nbeats, {28'h0, v[3:0]} + 32'h1);
      chk({28'h0, bid}, 32'h9);
      chk({28'h0, rid}, 32'h5);
      chk(rdata, 32'h0);
      rc(AERS_OFF_STATUS, 32'h3);
      rc(AERS_OFF_RD_STAT, 32'h1);
      rc(AERS_OFF_RD_BTYPE, {30'h0, v[8:7]});
      rc(AERS_OFF_RD_BLEN, {28'h0, v[3:0]});
      rc(AERS_OFF_RD_BSIZE, {29'h0, v[6:4]});
      rc(AERS_OFF_RD_STAT, 32'h0);
      cw(AERS_OFF_STATUS, 32'h1);
      rc(AERS_OFF_WR_STAT, 32'h0);
      rc(AERS_OFF_STATUS, 32'h0);
      // read overflow, then clearing flushes the read log
      for (int i = 0; i < 5; i++) mst.rd($random(seed), 4'h0, 3'h2, 2'h1, 0);
      rc(AERS_OFF_STATUS, 32'ha);
      cw(AERS_OFF_STATUS, 32'h2);
      rc(AERS_OFF_RD_STAT, 32'h0);
      rc(AERS_OFF_STATUS, 32'h8);
      cw(AERS_OFF_STATUS, 32'h8);
      rc(9'h050, 32'h0);
      chk({31'h0, irq}, 32'h0);
      summarize();
   end
endmodule : tb
bind aers_slave aers_monitor mon (.*);
